//--- hdl/rcs_lf_timer.sv
`timescale 1ns/100ps
`default_nettype none

module rcs_lf_timer #(
   parameter int unsigned WDOG_RC_CYC = 20000
) (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic clear_in,
   // Low-frequency side
   rcs_lf_if.tmr     lf_if
);

   localparam int unsigned WW = $clog2(WDOG_RC_CYC + 1);

   logic [7:0]    div_cnt;
   logic [7:0]    next_div_cnt;
   logic          next_tick;
   logic [WW-1:0] wd_cnt;
   logic [WW-1:0] next_wd_cnt;
   logic          next_expire;

   ////////////////////////////////////////////////////////////////////////
   // Divider and watchdog
   always_comb begin
      next_div_cnt = div_cnt;
      next_tick    = 1'b0;
      next_wd_cnt  = wd_cnt;
      next_expire  = 1'b0;
      // Ratio 0 behaves like 1 so a cleared register cannot stop the tick
      if (lf_if.rc_edge) begin
         if (div_cnt + 8'h01 >= lf_if.ratio) begin
            next_div_cnt = 8'h00;
            next_tick    = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 8'h01;
         end
      end
      // Counts raw RC edges, so the divider ratio does not change the timeout; held at zero outside SEQ_RUN
      if (!lf_if.run || lf_if.kick) begin
         next_wd_cnt = '0;
      end else if (lf_if.rc_edge) begin
         if (wd_cnt == WW'(WDOG_RC_CYC - 1)) begin
            next_wd_cnt = '0;
            next_expire = 1'b1;
         end else begin
            next_wd_cnt = wd_cnt + WW'(1);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (clear_in) begin
         div_cnt      <= 8'h00;
         lf_if.tick   <= 1'b0;
         wd_cnt       <= '0;
         lf_if.expire <= 1'b0;
      end else begin
         div_cnt      <= next_div_cnt;
         lf_if.tick   <= next_tick;
         wd_cnt       <= next_wd_cnt;
         lf_if.expire <= next_expire;
      end
   end

endmodule

`default_nettype wire

//--- hdl/rcs_reset_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcs_regs.svh"


module rcs_reset_seq #(
   parameter int unsigned WDOG_RC_CYC = `RCS_WDOG_RC_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // Pins and supply status
   input  wire logic        ext_reset_in_l,
   input  wire logic        pads_pg_in,
   input  wire logic        core_pg_in,
   input  wire logic        rc_clk_in,
   input  wire logic        xtal_clk_in,
   // CPU events
   input  wire logic        pc_rollover_in,
   // Register port
   input  wire logic [4:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // Resets and ticks
   output logic             pad_rst_n_out,
   output logic             core_rst_n_out,
   output logic             mgmt_tick_out,
   output logic             sleep_tick_out,
   output logic      [3:0]  rc_trim_out
);

   localparam int unsigned SN = 5;
   localparam int unsigned I_EXT = 4;
   localparam int unsigned I_PPG = 3;
   localparam int unsigned I_CPG = 2;
   localparam int unsigned I_RC = 1;
   localparam int unsigned I_XT = 0;
   localparam logic [5:0] GLITCH_CYC = 6'(`RCS_GLITCH_CYC);
   localparam logic [1:0] RC_PULSES = 2'(`RCS_RC_PULSES);
   localparam logic [10:0] XTAL_LAST = 11'(`RCS_XTAL_EDGES - 1);

   logic [SN-1:0]     sync1;
   logic [SN-1:0]     sync2;
   logic              rc_prev;
   logic              xt_prev;
   logic              rc_edge;
   logic              xt_edge;
   logic [5:0]        glitch_cnt;
   logic [5:0]        next_glitch_cnt;
   logic              ext_active;
   logic              next_ext_active;
   logic              sys_rst;
   rcs_pkg::rcs_seq_e state;
   rcs_pkg::rcs_seq_e next_state;
   logic [1:0]        rc_cnt;
   logic [1:0]        next_rc_cnt;
   logic [10:0]       xt_cnt;
   logic [10:0]       next_xt_cnt;
   logic              core_evt;
   logic              dip_evt;
   logic              sw_req;
   logic              kick;
   rcs_pkg::rcs_cause_t cause;
   rcs_pkg::rcs_cause_t next_cause;
   logic              ext_prev;
   logic [3:0]        trim;
   logic [3:0]        next_trim;
   logic [7:0]        ratio;
   logic [7:0]        next_ratio;
   logic [31:0]       next_rdata;

   rcs_lf_if lf ();

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect
   // Edges are taken from the second stage only; the 200 MHz sampling
   // is well above both the 24 MHz crystal and the RC clock.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sync1   <= 5'h18;
         sync2   <= 5'h18;
         rc_prev <= 1'b0;
         xt_prev <= 1'b0;
         rc_edge <= 1'b0;
         xt_edge <= 1'b0;
      end else begin
         sync1   <= {ext_reset_in_l, pads_pg_in, core_pg_in, rc_clk_in, xtal_clk_in};
         sync2   <= sync1;
         rc_prev <= sync2[I_RC];
         xt_prev <= sync2[I_XT];
         rc_edge <= sync2[I_RC] & ~rc_prev;
         xt_edge <= sync2[I_XT] & ~xt_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External reset glitch filter
   always_comb begin
      next_glitch_cnt = 6'h00;
      next_ext_active = 1'b0;
      if (!sync2[I_EXT]) begin
         // A low must persist GLITCH_CYC + 1 samples before it counts
         if (glitch_cnt == GLITCH_CYC) begin
            next_glitch_cnt = glitch_cnt;
            next_ext_active = 1'b1;
         end else begin
            next_glitch_cnt = glitch_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         glitch_cnt <= 6'h00;
         ext_active <= 1'b0;
         ext_prev   <= 1'b0;
      end else begin
         glitch_cnt <= next_glitch_cnt;
         ext_active <= next_ext_active;
         ext_prev   <= ext_active;
      end
   end

   assign sys_rst = !rst_n_in || ext_active;

   ////////////////////////////////////////////////////////////////////////
   // Release sequencer
   assign dip_evt  = (state == rcs_pkg::SEQ_RUN) && !sync2[I_CPG];
   assign core_evt = dip_evt || lf.expire || pc_rollover_in || sw_req;

   always_comb begin
      next_state  = state;
      next_rc_cnt = rc_cnt;
      next_xt_cnt = xt_cnt;
      if (state != rcs_pkg::SEQ_PAD && !sync2[I_PPG]) begin
         next_state  = rcs_pkg::SEQ_PAD;
         next_rc_cnt = 2'b00;
      end else begin
         unique case (state)
            rcs_pkg::SEQ_PAD: begin
               if (rc_edge && rc_cnt != RC_PULSES) begin
                  next_rc_cnt = rc_cnt + 2'b01;
               end
               if (sync2[I_PPG] && rc_cnt == RC_PULSES) begin
                  next_state = rcs_pkg::SEQ_PG;
               end
            end
            rcs_pkg::SEQ_PG: begin
               next_xt_cnt = 11'h000;
               if (sync2[I_CPG]) begin
                  next_state = rcs_pkg::SEQ_XTAL;
               end
            end
            rcs_pkg::SEQ_XTAL: begin
               if (!sync2[I_CPG]) begin
                  next_state = rcs_pkg::SEQ_PG;
               end else if (xt_edge) begin
                  if (xt_cnt == XTAL_LAST) begin
                     next_state = rcs_pkg::SEQ_RUN;
                  end else begin
                     next_xt_cnt = xt_cnt + 11'h001;
                  end
               end
            end
            rcs_pkg::SEQ_RUN: begin
               // Internal causes reset only the core; the pad domain stays up
               if (core_evt) begin
                  next_state = rcs_pkg::SEQ_PG;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst) begin
         state          <= rcs_pkg::SEQ_PAD;
         rc_cnt         <= 2'b00;
         xt_cnt         <= 11'h000;
         pad_rst_n_out  <= 1'b0;
         core_rst_n_out <= 1'b0;
      end else begin
         state          <= next_state;
         rc_cnt         <= next_rc_cnt;
         xt_cnt         <= next_xt_cnt;
         pad_rst_n_out  <= next_state != rcs_pkg::SEQ_PAD;
         core_rst_n_out <= next_state == rcs_pkg::SEQ_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset cause, kept across every reset except power-on
   always_comb begin
      next_cause = cause;
      if (ext_active && !ext_prev) begin
         next_cause = 8'h00;
         next_cause[`RCS_CAUSE_EXT] = 1'b1;
      end else if (state == rcs_pkg::SEQ_RUN && core_evt) begin
         next_cause = 8'h00;
         // One cause per event; a supply dip outranks the rest
         if (dip_evt) begin
            next_cause[`RCS_CAUSE_DIP] = 1'b1;
         end else if (lf.expire) begin
            next_cause[`RCS_CAUSE_WDOG] = 1'b1;
         end else if (pc_rollover_in) begin
            next_cause[`RCS_CAUSE_PC] = 1'b1;
         end else begin
            next_cause[`RCS_CAUSE_SW] = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cause <= `RCS_CAUSE_POR_VAL;
      end else begin
         cause <= next_cause;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port
   assign kick   = reg_wr_in && reg_addr_in == `RCS_ADDR_CTRL
                   && reg_wdata_in[`RCS_CTRL_KICK_BIT];
   assign sw_req = reg_wr_in && reg_addr_in == `RCS_ADDR_CTRL
                   && reg_wdata_in[`RCS_CTRL_SWRST_BIT];

   always_comb begin
      next_trim  = trim;
      next_ratio = ratio;
      next_rdata = 32'h0000_0000;
      if (reg_wr_in && reg_addr_in == `RCS_ADDR_TRIM) begin
         next_trim = reg_wdata_in[3:0];
      end
      if (reg_wr_in && reg_addr_in == `RCS_ADDR_DIV) begin
         next_ratio = reg_wdata_in[7:0];
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `RCS_ADDR_CAUSE:  next_rdata = {24'h00_0000, cause};
            `RCS_ADDR_TRIM:   next_rdata = {28'h000_0000, trim};
            `RCS_ADDR_DIV:    next_rdata = {24'h00_0000, ratio};
            `RCS_ADDR_STATUS: next_rdata = {26'h000_0000, core_rst_n_out, pad_rst_n_out,
                                            sync2[I_PPG], sync2[I_CPG], state};
            default:          next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst) begin
         trim          <= `RCS_TRIM_RST;
         ratio         <= `RCS_DIV_RST;
         reg_rdata_out <= 32'h0000_0000;
         mgmt_tick_out <= 1'b0;
      end else begin
         trim          <= next_trim;
         ratio         <= next_ratio;
         reg_rdata_out <= next_rdata;
         mgmt_tick_out <= rc_edge;
      end
   end

   assign rc_trim_out = trim;

   ////////////////////////////////////////////////////////////////////////
   // Low-frequency divider and watchdog
   assign lf.rc_edge     = rc_edge;
   assign lf.ratio       = ratio;
   assign lf.kick        = kick;
   assign lf.run         = state == rcs_pkg::SEQ_RUN;
   assign sleep_tick_out = lf.tick;

   rcs_lf_timer #(
      .WDOG_RC_CYC (WDOG_RC_CYC)
   ) u_lf (
      .ref_clk_in (ref_clk_in),
      .clear_in   (sys_rst),
      .lf_if      (lf.tmr)
   );

endmodule

`default_nettype wire

//--- shared/rcs_lf_if.sv
`timescale 1ns/100ps
`default_nettype none

interface rcs_lf_if;
   logic       rc_edge;
   logic [7:0] ratio;
   logic       kick;
   logic       run;
   logic       tick;
   logic       expire;

   modport ctl (output rc_edge, output ratio, output kick, output run,
                input tick, input expire);
   modport tmr (input rc_edge, input ratio, input kick, input run,
                output tick, output expire);
endinterface

`default_nettype wire

//--- shared/rcs_pkg.sv
package rcs_pkg;

   typedef enum logic [1:0] {
      SEQ_PAD  = 2'b00,
      SEQ_PG   = 2'b01,
      SEQ_XTAL = 2'b10,
      SEQ_RUN  = 2'b11
   } rcs_seq_e;

   typedef logic [7:0] rcs_cause_t;

endpackage

//--- shared/rcs_regs.svh
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// Register offsets (byte addresses, one 32-bit word each)
`define RCS_ADDR_CTRL     5'h00
`define RCS_ADDR_CAUSE    5'h04
`define RCS_ADDR_TRIM     5'h08
`define RCS_ADDR_DIV      5'h0C
`define RCS_ADDR_STATUS   5'h10

// Control register fields (write-only pulses)
`define RCS_CTRL_KICK_BIT 0
`define RCS_CTRL_SWRST_BIT 1

// Reset cause bits, one-hot
`define RCS_CAUSE_POR     0
`define RCS_CAUSE_WDOG    1
`define RCS_CAUSE_PC      2
`define RCS_CAUSE_SW      3
`define RCS_CAUSE_DIP     4
`define RCS_CAUSE_EXT     5
`define RCS_CAUSE_POR_VAL 8'h01

// Reset values
`define RCS_TRIM_RST      4'h8
`define RCS_DIV_RST       8'h0A

// Timing
`define RCS_CLK_MHZ       200
`define RCS_GLITCH_NS     200
`define RCS_GLITCH_CYC    ((`RCS_GLITCH_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_RC_PULSES     3
`define RCS_XTAL_EDGES    1024
`define RCS_WDOG_MS       2000
`define RCS_RC_KHZ        10
`define RCS_WDOG_RC_CYC   (`RCS_WDOG_MS * `RCS_RC_KHZ)

`endif

//--- sim/rcs_reset_seq_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_reset_seq_monitor #(
   parameter int unsigned WDOG_RC_CYC = 20000
) (
   // Clock, reset, pins
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ext_reset_in_l,
   input  wire logic        pads_pg_in,
   input  wire logic        core_pg_in,
   input  wire logic        rc_clk_in,
   input  wire logic        xtal_clk_in,
   input  wire logic        pc_rollover_in,
   // Register port
   input  wire logic [4:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_rdata_out,
   // Resets and ticks
   input  wire logic        pad_rst_n_out,
   input  wire logic        core_rst_n_out,
   input  wire logic        mgmt_tick_out,
   input  wire logic        sleep_tick_out,
   input  wire logic [3:0]  rc_trim_out
);
   logic        xtal_q;
   logic        ext_q;
   logic [7:0]  ext_lo;
   logic [11:0] xtal_cnt;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   ////////////////////////////////////////////////
   // Length of the current or latest low run on the pin; it is held after the pin
   // rises so a filter release a few cycles late is still judged on the right run
   always_ff @(posedge ref_clk_in) begin
      xtal_q <= xtal_clk_in;
      ext_q  <= ext_reset_in_l;
      if (!rst_n_in)
         ext_lo <= 8'h00;
      else if (!ext_reset_in_l)
         ext_lo <= ext_q ? 8'h01 : ext_lo + {7'h00, ext_lo != 8'hFF};
      if (!rst_n_in || !core_pg_in || !pad_rst_n_out || core_rst_n_out)
         xtal_cnt <= 12'h000;
      else if (xtal_clk_in && !xtal_q)
         xtal_cnt <= xtal_cnt + 12'h001;
   end

   ////////////////////////////////////////////////
   sequence quiet_pin;
      ext_reset_in_l && $past(ext_reset_in_l, 8);
   endsequence
   sequence pads_steady;
      pads_pg_in [*8];
   endsequence

   reset_clear_a: assert property (disable iff (1'b0) !rst_n_in [*2] |->
      !pad_rst_n_out && !core_rst_n_out && rc_trim_out == 4'h8 && reg_rdata_out == 32'h0)
      else $error("outputs not at reset values");
   pad_first_a: assert property (core_rst_n_out |-> pad_rst_n_out)
      else $error("core released while pad held");
   pads_hold_a: assert property (!pads_pg_in [*6] |-> !pad_rst_n_out)
      else $error("pad released without pad power");
   core_hold_a: assert property (!core_pg_in [*6] |-> !core_rst_n_out)
      else $error("core released without core power");
   xtal_wait_a: assert property ($rose(core_rst_n_out) |->
      xtal_cnt >= 12'h3FF && xtal_cnt <= 12'h402) else $error("core release count wrong");
   long_low_a: assert property (!ext_reset_in_l && ext_lo == 8'h32 |->
      !pad_rst_n_out && !core_rst_n_out) else $error("long pin low ignored");
   glitch_skip_a: assert property (pads_steady ##1 $fell(pad_rst_n_out) |->
      ext_lo >= 8'h29) else $error("short pin low caused reset");
   mgmt_follow_a: assert property (quiet_pin ##0 $rose(rc_clk_in) |->
      ##[1:6] mgmt_tick_out) else $error("management tick missing");
   mgmt_pulse_a: assert property (mgmt_tick_out |=> !mgmt_tick_out [*4])
      else $error("management tick too long");
   trim_write_a: assert property (quiet_pin ##0 (reg_wr_in && reg_addr_in == `RCS_ADDR_TRIM)
      |=> {28'h0, rc_trim_out} == ($past(reg_wdata_in) & 32'hF)) else $error("trim not written");
   cause_hot_a: assert property (quiet_pin ##0 (reg_rd_in && reg_addr_in == `RCS_ADDR_CAUSE)
      |=> $onehot(reg_rdata_out)) else $error("cause not one-hot");
   read_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
      else $error("read data outside read slot");
endmodule

bind rcs_reset_seq rcs_reset_seq_monitor #(.WDOG_RC_CYC(WDOG_RC_CYC)) i_mon (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ext_reset_in_l(ext_reset_in_l),
   .pads_pg_in(pads_pg_in), .core_pg_in(core_pg_in), .rc_clk_in(rc_clk_in),
   .xtal_clk_in(xtal_clk_in), .pc_rollover_in(pc_rollover_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .pad_rst_n_out(pad_rst_n_out),
   .core_rst_n_out(core_rst_n_out), .mgmt_tick_out(mgmt_tick_out),
   .sleep_tick_out(sleep_tick_out), .rc_trim_out(rc_trim_out));

`default_nettype wire

//--- sim/rcs_reset_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcs_regs.svh"

module rcs_reset_seq_tb;
   logic        clk;
   logic        rst_n;
   logic        pc;
   logic [4:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [3:0]  trim;
   logic        pad, core, mgmt, slp;
   logic        ext_l, pads_pg, core_pg, rc, xtal;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          nm, ns, nw;
   localparam logic [31:0] CAUSE_EXP [4] = '{32'h4, 32'h8, 32'h2, 32'h10};

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   rcs_supervisor i_sup (.ref_clk_in(clk), .ext_reset_l_out(ext_l), .pads_pg_out(pads_pg),
      .core_pg_out(core_pg), .rc_clk_out(rc), .xtal_clk_out(xtal));
   rcs_reset_seq #(.WDOG_RC_CYC(64)) i_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
      .ext_reset_in_l(ext_l), .pads_pg_in(pads_pg), .core_pg_in(core_pg), .rc_clk_in(rc),
      .xtal_clk_in(xtal), .pc_rollover_in(pc), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pad_rst_n_out(pad),
      .core_rst_n_out(core), .mgmt_tick_out(mgmt), .sleep_tick_out(slp), .rc_trim_out(trim));

   ////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Bounded wait for a reset output to release; counts RC ticks seen on the way
   task automatic wait_rel(input logic sel, input int lim);
      int n;
      n = 0;
      nw = 0;
      while ((sel ? core : pad) !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
         nw += (mgmt === 1'b1);
      end
      chk_bit(sel ? core : pad, 1'b1);
   endtask

   task automatic ticks(input int n);
      nm = 0;
      ns = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         nm += (mgmt === 1'b1);
         ns += (slp === 1'b1);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      pc = 1'b0;
      addr = 5'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(`RCS_ADDR_TRIM, 32'h8);
      rd_chk(`RCS_ADDR_DIV, 32'hA);
      rd_chk(`RCS_ADDR_CAUSE, 32'h1);
      rd_chk(5'h14, 32'h0);
      // RC pulses are long done here, so only pad power can still hold the pad domain
      repeat (200) @(posedge clk);
      chk_bit(pad, 1'b0);
      i_sup.set_pg(1'b1, 1'b0);
      wait_rel(1'b0, 400);
      repeat (200) @(posedge clk);
      chk_bit(core, 1'b0);
      i_sup.set_pg(1'b1, 1'b1);
      repeat (4000) @(posedge clk);
      chk_bit(core, 1'b0);
      wait_rel(1'b1, 6000);
      rd_chk(`RCS_ADDR_STATUS, 32'h3F);
      $display("power-up test done");
      wr_reg(`RCS_ADDR_CTRL, 32'h1);
      wr_reg(`RCS_ADDR_TRIM, 32'h3);
      #1;
      chk({28'h0, trim}, 32'h3);
      wr_reg(`RCS_ADDR_DIV, 32'h3);
      ticks(1200);
      chk_rng(nm, 29, 31);
      chk_rng(ns, 9, 11);
      wr_reg(`RCS_ADDR_CTRL, 32'h1);
      i_sup.hold_low(20);
      repeat (60) @(posedge clk);
      chk_bit(pad & core, 1'b1);
      $display("clock and glitch test done");
      // Core events: rollover, software, watchdog, supply dip
      for (int k = 0; k < 4; k++) begin
         wr_reg(`RCS_ADDR_CTRL, 32'h1);
         case (k)
            0: begin
               pc <= 1'b1;
               @(posedge clk);
               pc <= 1'b0;
            end
            1: wr_reg(`RCS_ADDR_CTRL, 32'h2);
            2: begin
               repeat (1500) @(posedge clk);
               wr_reg(`RCS_ADDR_CTRL, 32'h1);
               repeat (1500) @(posedge clk);
               chk_bit(core, 1'b1);
               repeat (1200) @(posedge clk);
            end
            default: i_sup.set_pg(1'b1, 1'b0);
         endcase
         repeat (20) @(posedge clk);
         chk_bit(core, 1'b0);
         chk_bit(pad, 1'b1);
         rd_chk(`RCS_ADDR_CAUSE, CAUSE_EXP[k]);
         i_sup.set_pg(1'b1, 1'b1);
         wait_rel(1'b1, 10000);
      end
      // Pad supply loss in run drops both domains and leaves the cause alone
      i_sup.set_pg(1'b0, 1'b1);
      repeat (20) @(posedge clk);
      chk_bit(pad | core, 1'b0);
      rd_chk(`RCS_ADDR_CAUSE, 32'h10);
      i_sup.set_pg(1'b1, 1'b1);
      wait_rel(1'b0, 400);
      wait_rel(1'b1, 10000);
      $display("core event test done");
      wr_reg(`RCS_ADDR_TRIM, 32'h5);
      wr_reg(`RCS_ADDR_CTRL, 32'h1);
      i_sup.hold_low(100);
      chk_bit(pad | core, 1'b0);
      wait_rel(1'b0, 400);
      chk_rng(nw, 3, 3);
      rd_chk(`RCS_ADDR_TRIM, 32'h8);
      rd_chk(`RCS_ADDR_CAUSE, 32'h20);
      wait_rel(1'b1, 10000);
      $display("pin reset test done");
      print_verdict();
   end

   // Whole run needs about 70000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         print_verdict();
      end
   end
endmodule

`default_nettype wire

//--- sim/rcs_supervisor.sv
`timescale 1ns/100ps
`default_nettype none

module rcs_supervisor (
   // Reference clock
   input  wire logic ref_clk_in,
   // Pins driven into the sequencer
   output logic      ext_reset_l_out,
   output logic      pads_pg_out,
   output logic      core_pg_out,
   output logic      rc_clk_out,
   output logic      xtal_clk_out
);
   ////////////////////////////////////////////////
   // RC sped up to 40 reference cycles; the odd phase keeps both clocks off the grid
   initial begin
      ext_reset_l_out = 1'b1;
      pads_pg_out = 1'b0;
      core_pg_out = 1'b0;
      rc_clk_out = 1'b0;
      xtal_clk_out = 1'b0;
      #1.3;
      fork
         forever #100 rc_clk_out = ~rc_clk_out;
         forever #21 xtal_clk_out = ~xtal_clk_out;
      join
   end

   task automatic set_pg(input logic pads, input logic core);
      @(posedge ref_clk_in);
      pads_pg_out <= pads;
      core_pg_out <= core;
   endtask

   task automatic hold_low(input int cyc);
      @(posedge ref_clk_in);
      ext_reset_l_out <= 1'b0;
      repeat (cyc) @(posedge ref_clk_in);
      ext_reset_l_out <= 1'b1;
   endtask
endmodule

`default_nettype wire
